// ### rtl/swp_err_sync.sv
/*
  Carries a pulse from the link clock into the user read clock as a flag held four cycles.
  Assumes both clocks run; each side has its own synchronous reset.
*/
`include "swp_regs.svh"
module swp_err_sync
(
  input  wire logic clk_link,
  input  wire logic rst_link,
  input  wire logic pulse_link,
  input  wire logic clk_user,
  input  wire logic rst_user,
  output logic      flag_user
);
  logic       tog_q;
  logic [2:0] sync_q;
  logic [1:0] hold_q;
  logic       flag_q;

  // --------------------------------------------------------------------
  // Toggle in link domain
  // --------------------------------------------------------------------
  always_ff @(posedge clk_link)
  begin
    if (rst_link)
      tog_q <= 1'b0;
    else if (pulse_link)
      tog_q <= ~tog_q;
  end

  // --------------------------------------------------------------------
  // Synchronise, detect edge, stretch
  // --------------------------------------------------------------------
  always_ff @(posedge clk_user)
  begin
    if (rst_user)
      sync_q <= 3'h0;
    else
      sync_q <= {sync_q[1:0], tog_q};
  end

  always_ff @(posedge clk_user)
  begin
    if (rst_user)
    begin
      hold_q <= 2'h0;
      flag_q <= 1'b0;
    end
    else if (sync_q[2] != sync_q[1])
    begin
      hold_q <= `SWP_ERR_HOLD_CYC;
      flag_q <= 1'b1;
    end
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
    else
      flag_q <= 1'b0;
  end

  assign flag_user = flag_q;
endmodule : swp_err_sync

// ### rtl/swp_pkg.sv
/*
  Types for the sink word packer.
  Assumes no surroundings beyond the compiler.
*/
package swp_pkg;
  typedef logic [15:0] swp_word_t;
  typedef logic [2:0]  swp_vbc_t;
endpackage : swp_pkg

// ### rtl/swp_regs.svh
/*
  Constants of the sink word packer: control word fields, end codes, spacing.
  Assumes inclusion by bare name from rtl/.
*/
`ifndef SWP_REGS_SVH
`define SWP_REGS_SVH
`define SWP_CW_PAYLOAD_BIT  15
`define SWP_CW_SOP_BIT      12
`define SWP_CW_EOP_HI       14
`define SWP_CW_EOP_LO       13
`define SWP_CW_CHAN_HI      11
`define SWP_CW_CHAN_LO      4
`define SWP_CW_DIP_HI       3
`define SWP_EOP_NONE        2'b00
`define SWP_EOP_ABORT       2'b01
`define SWP_EOP_EVEN        2'b10
`define SWP_EOP_ODD         2'b11
`define SWP_SOP_MIN_SPACING 4'h8
`define SWP_LANE_LAST       2'h3
`define SWP_ERR_HOLD_CYC    2'h3
`endif

// ### rtl/swp_sink_word_packer.sv
/*
  Receive-side packer: decodes link control words, packs 16-bit payload into
  left-justified 64-bit words with start, end, valid-byte, abort and channel.
  Assumes the link data and control are already sampled on the link clock,
  the user side reads with an external asynchronous FIFO, so word output here
  stays on the link clock; only the protocol error flag crosses to the user
  read clock.
*/
// What this block does
// - Close starts: pass data, raise protocol error
// - Close non-start bursts: no error raised
// - Control-data alternation handled without idles
// - First word after start in bits 63:48
// - Pack four words, earliest in top lane
// - Start word sets start flag, loads channel
// - Burst word loads channel, no start flag
// - Even end sets end, even byte code
// - Odd end sets end, odd byte code
// - One-word packet carries start and end
// - Packets and channels never share words
// - Parity covers control word and preceding data
// - Error held four user clock cycles, crossed to user clock
`include "swp_regs.svh"
module swp_sink_word_packer
(
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic               link_clk,
  input  wire logic               link_rst,
  input  wire swp_pkg::swp_word_t link_data,
  input  wire logic               link_ctl,
  input  wire logic               user_read_clock,
  output logic                    fifo_write,
  output logic [63:0]             fifo_read_word,
  output logic                    fifo_start,
  output logic                    fifo_end,
  output swp_pkg::swp_vbc_t       fifo_valid_byte_code,
  output logic                    fifo_packet_abort,
  output logic [7:0]              fifo_channel_number,
  output logic                    parity_error,
  output logic                    protocol_error_flag,
  output logic                    protocol_error_sys
);
  logic [63:0]  acc_q;
  logic [1:0]   lane_q;
  logic         have_q;
  logic         sop_pend_q;
  logic [7:0]   chan_q;
  logic [3:0]   since_sop_q;
  logic         sop_seen_q;
  logic [3:0]   dip_q;
  logic         ctl_prev_q;
  swp_pkg::swp_word_t prev_data_q;
  logic         viol_pulse;
  logic         sys_s1_q;
  logic         sys_s2_q;
  logic         full_q;
  logic         flush;

  logic         is_pay;
  logic         is_sop;
  logic [1:0]   eop_kind;
  logic         data_in;

  assign data_in  = ~link_ctl;
  assign is_pay   = link_ctl & link_data[`SWP_CW_PAYLOAD_BIT];
  assign is_sop   = is_pay & link_data[`SWP_CW_SOP_BIT];
  assign eop_kind = link_ctl ? link_data[`SWP_CW_EOP_HI:`SWP_CW_EOP_LO] : `SWP_EOP_NONE;

  // Valid-byte code from lanes filled and odd flag; 00 when all eight bytes
  function automatic swp_pkg::swp_vbc_t vbc(input logic [1:0] lanes_m1, input logic odd);
    logic [2:0] bytes;
    bytes = {lanes_m1, 1'b0} + 3'h2 - {2'b00, odd};
    vbc = bytes;
  endfunction : vbc

  // DIP-4 over a 16-bit word folded into four bits
  function automatic logic [3:0] fold4(input logic [15:0] w);
    fold4 = w[15:12] ^ w[11:8] ^ w[7:4] ^ w[3:0];
  endfunction : fold4

  // --------------------------------------------------------------------
  // Parity over data since last control word and the control word
  // --------------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      dip_q        <= 4'h0;
      parity_error <= 1'b0;
    end
    else if (link_ctl)
    begin
      dip_q        <= 4'h0;
      parity_error <= (fold4(link_data) ^ dip_q) != 4'hF;
    end
    else
    begin
      dip_q        <= dip_q ^ fold4(link_data);
      parity_error <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Start spacing monitor
  // --------------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      since_sop_q <= 4'h0;
      sop_seen_q  <= 1'b0;
    end
    else if (is_sop)
    begin
      since_sop_q <= 4'h1;
      sop_seen_q  <= 1'b1;
    end
    else if (since_sop_q != `SWP_SOP_MIN_SPACING)
      since_sop_q <= since_sop_q + 4'h1;
  end

  // Only starts count; plain burst words never trip this
  assign viol_pulse = is_sop & sop_seen_q & (since_sop_q < `SWP_SOP_MIN_SPACING);

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      ctl_prev_q <= 1'b0;
    else
      ctl_prev_q <= link_ctl;
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      prev_data_q <= 16'h0000;
    else if (data_in)
      prev_data_q <= link_data;
  end

  // --------------------------------------------------------------------
  // Channel and start tracking
  // --------------------------------------------------------------------
  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      chan_q <= 8'h00;
    else if (is_pay)
      chan_q <= link_data[`SWP_CW_CHAN_HI:`SWP_CW_CHAN_LO];
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
      sop_pend_q <= 1'b0;
    else if (is_pay)
      sop_pend_q <= is_sop;
    else if (full_q || flush)
      sop_pend_q <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Lane packing and word output
  // --------------------------------------------------------------------
  assign flush = link_ctl & have_q & ((eop_kind != `SWP_EOP_NONE) | is_pay);

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      acc_q  <= 64'h0000_0000_0000_0000;
      lane_q <= 2'h0;
      have_q <= 1'b0;
      full_q <= 1'b0;
    end
    else if (data_in)
    begin
      if (lane_q == 2'h0)
        acc_q <= {link_data, 48'h0000_0000_0000};
      else
        acc_q[(3 - lane_q) * 16 +: 16] <= link_data;
      lane_q <= lane_q + 2'h1;
      have_q <= (lane_q != `SWP_LANE_LAST);
      // Full word waits one cycle so a following end can still mark it
      full_q <= (lane_q == `SWP_LANE_LAST);
    end
    else if (flush)
    begin
      lane_q <= 2'h0;
      have_q <= 1'b0;
      full_q <= 1'b0;
    end
    else
      full_q <= 1'b0;
  end

  always_ff @(posedge link_clk)
  begin
    if (link_rst)
    begin
      fifo_write           <= 1'b0;
      fifo_read_word       <= 64'h0000_0000_0000_0000;
      fifo_start           <= 1'b0;
      fifo_end             <= 1'b0;
      fifo_valid_byte_code <= 3'h0;
      fifo_packet_abort    <= 1'b0;
      fifo_channel_number  <= 8'h00;
    end
    else if (full_q)
    begin
      // Full word; passed even when starts came too close
      fifo_write           <= 1'b1;
      fifo_read_word       <= acc_q;
      fifo_start           <= sop_pend_q;
      fifo_end             <= eop_kind != `SWP_EOP_NONE;
      fifo_valid_byte_code <= vbc(`SWP_LANE_LAST, eop_kind == `SWP_EOP_ODD);
      fifo_packet_abort    <= eop_kind == `SWP_EOP_ABORT;
      fifo_channel_number  <= chan_q;
    end
    else if (flush)
    begin
      fifo_write           <= 1'b1;
      fifo_read_word       <= acc_q;
      fifo_start           <= sop_pend_q;
      fifo_end             <= eop_kind != `SWP_EOP_NONE;
      fifo_packet_abort    <= eop_kind == `SWP_EOP_ABORT;
      fifo_channel_number  <= chan_q;
      if (eop_kind == `SWP_EOP_ODD)
        fifo_valid_byte_code <= vbc(lane_q - 2'h1, 1'b1);
      else
        fifo_valid_byte_code <= vbc(lane_q - 2'h1, 1'b0);
    end
    else
      fifo_write           <= 1'b0;
  end

  // --------------------------------------------------------------------
  // Error flag crossing into user read clock and system clock
  // --------------------------------------------------------------------
  swp_err_sync u_err_sync
  (
    .clk_link   (link_clk),
    .rst_link   (link_rst),
    .pulse_link (viol_pulse),
    .clk_user   (user_read_clock),
    .rst_user   (srst),
    .flag_user  (protocol_error_flag)
  );

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sys_s1_q <= 1'b0;
      sys_s2_q <= 1'b0;
    end
    else
    begin
      sys_s1_q <= protocol_error_flag;
      sys_s2_q <= sys_s1_q;
    end
  end

  assign protocol_error_sys = sys_s2_q;
endmodule : swp_sink_word_packer

// ### verif/swp_link_tx.sv
/* Link transmitter model: words change on the falling edge, parity per control word.
   Assumes the caller waits for reset release. */
module swp_link_tx
(
  input wire logic         link_clk,
  output swp_pkg::swp_word_t link_data,
  output logic             link_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] fold = 4'h0;
  initial link_ctl = 1'b1;
  initial link_data = 16'h000f;
  task automatic send(input logic ctl, input swp_pkg::swp_word_t w, input logic bad);
    @(negedge link_clk);
    link_ctl = ctl;
    link_data = ctl ? {w[15:4], 4'hf ^ fold ^ w[15:12] ^ w[11:8] ^ w[7:4] ^ {3'h0, bad}}
                    : w;
    fold = ctl ? 4'h0 : fold ^ w[15:12] ^ w[11:8] ^ w[7:4] ^ w[3:0];
  endtask : send
endmodule : swp_link_tx

// ### verif/swp_sink_word_packer_sva.sv
/* Checker on the sink word packer ports.
   Assumes binding onto swp_sink_word_packer. */
module swp_sink_word_packer_sva
(
  input wire logic               clk_sys,
  input wire logic               srst,
  input wire logic               link_clk,
  input wire logic               link_rst,
  input wire swp_pkg::swp_word_t link_data,
  input wire logic               link_ctl,
  input wire logic               user_read_clock,
  input wire logic               fifo_write,
  input wire logic [63:0]        fifo_read_word,
  input wire logic               fifo_start,
  input wire logic               fifo_end,
  input wire swp_pkg::swp_vbc_t  fifo_valid_byte_code,
  input wire logic               fifo_packet_abort,
  input wire logic [7:0]         fifo_channel_number,
  input wire logic               parity_error,
  input wire logic               protocol_error_flag,
  input wire logic               protocol_error_sys
);
  a_fields_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    !fifo_write |-> $stable(fifo_read_word) && $stable(fifo_channel_number))
    else $error("word moved without write");
  a_abort_end: assert property (@(posedge link_clk) disable iff (link_rst)
    fifo_write && fifo_packet_abort |-> fifo_end) else $error("abort without end");
  a_tail_one: assert property (@(posedge link_clk) disable iff (link_rst)
    fifo_write && fifo_end && fifo_valid_byte_code inside {3'h1, 3'h2}
    |-> fifo_read_word[47:0] == 48'h0) else $error("one lane tail not clean");
  a_tail_two: assert property (@(posedge link_clk) disable iff (link_rst)
    fifo_write && fifo_end && fifo_valid_byte_code inside {3'h3, 3'h4}
    |-> fifo_read_word[31:0] == 32'h0) else $error("two lane tail not clean");
  a_sop_start: assert property (@(posedge link_clk) disable iff (link_rst)
    link_ctl && link_data[15] && link_data[12] ##1 !link_ctl [*4]
    |-> ##[1:2] fifo_write && fifo_start) else $error("start flag missing");
  a_parity_cause: assert property (@(posedge link_clk) disable iff (link_rst)
    parity_error |-> $past(link_ctl) || $past(link_ctl, 2)) else $error("parity without ctl");
  a_err_sys_lag: assert property (@(posedge clk_sys) disable iff (srst)
    protocol_error_sys == $past(protocol_error_flag, 2)) else $error("sys error lag wrong");
  a_err_holds: assert property (@(posedge user_read_clock) disable iff (srst)
    $rose(protocol_error_flag) |=> protocol_error_flag [*3]) else $error("error not held");
endmodule : swp_sink_word_packer_sva

// ### verif/swp_sink_word_packer_tb.sv
/* Bench for the sink word packer: link packets in, captured words compared.
   Assumes the link model and the checker are compiled before it. */
module swp_sink_word_packer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys = 1'b0;
  logic               link_clk = 1'b0;
  logic               srst = 1'b1;
  logic               link_rst = 1'b1;
  logic               err_seen = 1'b0;
  logic               par_seen = 1'b0;
  swp_pkg::swp_word_t link_data;
  swp_pkg::swp_vbc_t  fifo_valid_byte_code;
  logic               link_ctl, fifo_write, fifo_start, fifo_end, fifo_packet_abort;
  logic               parity_error, protocol_error_flag, protocol_error_sys;
  logic [63:0]        fifo_read_word, exp_w;
  logic [7:0]         fifo_channel_number;
  logic [77:0]        q[$];
  logic [77:0]        g;
  int                 failures = 0;
  int                 checked = 0;
  int                 cyc = 0;
  swp_pkg::swp_word_t tbl[10] = '{16'hf1e2, 16'hd3c4, 16'hb5a6, 16'hf9e8, 16'h1f2e,
                                  16'h3d4c, 16'h5b6a, 16'h9f8e, 16'habcd, 16'h1200};
  initial forever #4 clk_sys = ~clk_sys;
  initial #1.3 forever #3 link_clk = ~link_clk;
  swp_sink_word_packer i_swp_sink_word_packer (.clk_sys, .srst, .link_clk, .link_rst,
    .link_data, .link_ctl, .user_read_clock(clk_sys), .fifo_write, .fifo_read_word,
    .fifo_start, .fifo_end, .fifo_valid_byte_code, .fifo_packet_abort,
    .fifo_channel_number, .parity_error, .protocol_error_flag, .protocol_error_sys);
  swp_link_tx i_swp_link_tx (.link_clk, .link_data, .link_ctl);
  // ----------------------------------------
  // Capture of written words and flags
  // ----------------------------------------
  always @(negedge link_clk)
  begin
    if (fifo_write === 1'b1)
      q.push_back({fifo_read_word, fifo_start, fifo_end, fifo_packet_abort,
                   fifo_valid_byte_code, fifo_channel_number});
    if (parity_error === 1'b1)
      par_seen = 1'b1;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (protocol_error_flag === 1'b1)
      err_seen = 1'b1;
    if (cyc == 20000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [77:0] got, input logic [77:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tx(input logic ctl, input swp_pkg::swp_word_t w);
    i_swp_link_tx.send(ctl, w, 1'b0);
  endtask : tx
  task automatic pkt(input swp_pkg::swp_word_t sop, input int n, input swp_pkg::swp_word_t eop);
    tx(1'b1, sop);
    for (int k = 0; k < n; k++)
      tx(1'b0, tbl[k]);
    tx(1'b1, eop);
    repeat (8) tx(1'b1, 16'h0000);
    exp_w = 64'h0;
    for (int k = 4 * ((n - 1) / 4); k < n; k++)
      exp_w[63 - 16 * (k % 4) -: 16] = tbl[k];
  endtask : pkt
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) srst = 1'b0;
    @(negedge link_clk) link_rst = 1'b0;
    pkt(16'h9020, 10, 16'h6000);
    chk(q.pop_front(), {64'hf1e2_d3c4_b5a6_f9e8, 6'h20, 8'h02});
    chk(q.pop_front(), {64'h1f2e_3d4c_5b6a_9f8e, 6'h00, 8'h02});
    chk(q.pop_front(), {exp_w, 6'h13, 8'h02});
    $display("table packet done");
    for (int b = 1; b < 8; b++)
    begin
      pkt({8'h90, 4'(b), 4'h0}, (b + 1) / 2, {2'b01, 1'(b % 2), 13'h0});
      chk(q.pop_front(), {exp_w, 3'b110, 3'(b), 4'h0, 4'(b)});
    end
    pkt(16'h9030, 3, 16'h2000);
    chk(q.pop_front(), {exp_w, 6'h3e, 8'h03});
    $display("short packets done");
    tx(1'b1, 16'h9010);
    for (int k = 1; k < 4; k++)
    begin
      tx(1'b0, 16'(16'h1111 * k));
      tx(1'b1, k < 3 ? {8'h80, 4'(k + 4), 4'h0} : 16'h4000);
    end
    repeat (8) tx(1'b1, 16'h0000);
    for (int k = 1; k < 4; k++)
    begin
      g = q.pop_front();
      chk({g[77:13], g[7:0]}, {16'(16'h1111 * k), 48'h0, k == 1, 8'(k == 1 ? 1 : k + 3)});
    end
    chk(err_seen, 1'b0);
    $display("alternation done");
    tx(1'b1, 16'h9010);
    tx(1'b0, 16'haaaa);
    tx(1'b1, 16'hd020);
    tx(1'b0, 16'hbbbb);
    tx(1'b1, 16'h4000);
    repeat (8) tx(1'b1, 16'h0000);
    chk(q.pop_front(), {64'haaaa_0000_0000_0000, 6'h32, 8'h01});
    chk(q.pop_front(), {64'hbbbb_0000_0000_0000, 6'h32, 8'h02});
    repeat (20) if (err_seen !== 1'b1) @(posedge clk_sys);
    chk(err_seen, 1'b1);
    chk(par_seen, 1'b0);
    i_swp_link_tx.send(1'b1, 16'h0000, 1'b1);
    repeat (2) tx(1'b1, 16'h0000);
    chk(par_seen, 1'b1);
    $display("error flags done");
    tally_and_finish();
  end
endmodule : swp_sink_word_packer_tb
bind swp_sink_word_packer swp_sink_word_packer_sva i_swp_sink_word_packer_sva (.clk_sys,
  .srst, .link_clk, .link_rst, .link_data, .link_ctl, .user_read_clock, .fifo_write,
  .fifo_read_word, .fifo_start, .fifo_end, .fifo_valid_byte_code, .fifo_packet_abort,
  .fifo_channel_number, .parity_error, .protocol_error_flag, .protocol_error_sys);
